//--- logic/imlb_top.sv
// interrupt mask, latched readback and bias/tolerance config registers
// Notes on behaviour
// - mask bits 7..3 gate five events
// - mask register resets to all ones
// - latch uses mask bit order
// - latch flags clear after being read
// - latch register resets to zero
// - two-bit tolerance fields per channel
// - bias field bits 6-4, code 7 is input
// - full-scale field bits 1-0
// - polarity bit selects pin level
// - level, repeating or single pulse modes
// - readback shows all or unmasked events
`timescale 1ns/1ps
`default_nettype none
module imlb_top
    import imlb_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic [9:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic clk_err_in,
    input wire logic pll_lock_in,
    input wire logic mix_sat_in,
    input wire logic vad_up_in,
    input wire logic vad_down_in,
    output logic irq_active_low_pin_out,
    output logic irq_out,
    output logic [1:0] chan_one_tolerance_sel_out,
    output logic [1:0] chan_two_tolerance_sel_out,
    output logic [2:0] bias_source_sel_out,
    output logic bias_pin_is_input_out,
    output logic [1:0] full_scale_sel_out
);
    logic [7:0] event_mask_bits_q;
    logic [7:0] event_latch_bits_q;
    logic [7:0] tol_q;
    logic [7:0] bias_q;
    logic [7:0] intcfg_q;
    logic [4:0] stat_q;
    logic [4:0] smask_q;
    logic [4:0] ev_s1_q;
    logic [4:0] ev_s2_q;
    logic [4:0] ev_s3_q;
    logic [4:0] ev_pulse;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [7:0] idx;
    logic wr_go;
    logic rd_go;
    logic [7:0] wbyte;
    logic [7:0] latch_view;
    logic pending;
    logic pin_active;
    logic [7:0] pend_bits;

    function automatic logic [7:0] evt_bits(input logic [4:0] e);
        evt_bits = {e, 3'h0};
    endfunction

    assign idx = avs_address_in[9:2];
    assign wbyte = avs_writedata_in[7:0];
    // write lands on the edge where waitrequest is seen low
    assign wr_go = clk_en_in && avs_write_in && ack_q && avs_byteenable_in[0];
    assign rd_go = clk_en_in && avs_read_in && !ack_q;
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_q;
    assign avs_readdata_out = rdata_q;

    // pins from outside pass two flops; third flop finds rising edges
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ev_s1_q <= '0;
            ev_s2_q <= '0;
            ev_s3_q <= '0;
        end else if (clk_en_in) begin
            ev_s1_q <= {clk_err_in, pll_lock_in, mix_sat_in, vad_up_in,
                vad_down_in};
            ev_s2_q <= ev_s1_q;
            ev_s3_q <= ev_s2_q;
        end
    end
    assign ev_pulse = ev_s2_q & ~ev_s3_q;

    // one wait state, then ack for one cycle
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ack_q <= 1'b0;
        end else if (clk_en_in) begin
            ack_q <= (avs_read_in || avs_write_in) && !ack_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            event_mask_bits_q <= IMLB_MASK_RST;
            tol_q <= IMLB_CFG_RST;
            bias_q <= IMLB_CFG_RST;
            intcfg_q <= IMLB_CFG_RST;
            smask_q <= IMLB_SMASK_RST;
        end else if (wr_go) begin
            unique case (idx)
                IMLB_IDX_MASK: event_mask_bits_q <= wbyte;
                IMLB_IDX_TOL: tol_q <= wbyte & IMLB_TOL_BITS;
                IMLB_IDX_BIAS: bias_q <= wbyte & IMLB_BIAS_BITS;
                IMLB_IDX_INTCFG: intcfg_q <= wbyte & IMLB_INTCFG_BITS;
                IMLB_IDX_SMASK: smask_q <= wbyte[IMLB_NEVT-1:0];
                default: ;
            endcase
        end
    end

    // readback filtered by the readback select bit
    assign latch_view = intcfg_q[IMLB_RDSEL_BIT]
        ? (event_latch_bits_q & ~event_mask_bits_q & IMLB_EVT_BITS)
        : event_latch_bits_q;

    // latch: set wins over the read clear
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            event_latch_bits_q <= IMLB_LATCH_RST;
        end else if (clk_en_in) begin
            event_latch_bits_q <= ((rd_go && idx == IMLB_IDX_LATCH)
                ? 8'h00 : event_latch_bits_q)
                | (evt_bits(ev_pulse) & IMLB_EVT_BITS);
        end
    end

    // status for software, write one to clear
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            stat_q <= '0;
        end else if (clk_en_in) begin
            stat_q <= (wr_go && idx == IMLB_IDX_STAT
                ? stat_q & ~wbyte[IMLB_NEVT-1:0] : stat_q) | ev_pulse;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdata_q <= '0;
        end else if (rd_go) begin
            rdata_q <= '0;
            unique case (idx)
                IMLB_IDX_MASK: rdata_q[7:0] <= event_mask_bits_q;
                IMLB_IDX_LATCH: rdata_q[7:0] <= latch_view;
                IMLB_IDX_TOL: rdata_q[7:0] <= tol_q;
                IMLB_IDX_BIAS: rdata_q[7:0] <= bias_q;
                IMLB_IDX_INTCFG: rdata_q[7:0] <= intcfg_q;
                IMLB_IDX_STAT: rdata_q[4:0] <= stat_q;
                IMLB_IDX_SMASK: rdata_q[4:0] <= smask_q;
                default: ;
            endcase
        end
    end

    assign pend_bits = event_latch_bits_q & ~event_mask_bits_q
        & IMLB_EVT_BITS;
    assign pending = |pend_bits;

    imlb_pulse_gen u_pulse (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .enable_in(clk_en_in),
        .mode_in(intcfg_q[IMLB_MODE_LO+1:IMLB_MODE_LO]),
        .pending_in(pending),
        .new_event_in(|(evt_bits(ev_pulse) & ~event_mask_bits_q)),
        .active_out(pin_active)
    );

    // polarity 0: active low
    assign irq_active_low_pin_out = intcfg_q[IMLB_POL_BIT]
        ? pin_active : !pin_active;
    assign irq_out = |(stat_q & ~smask_q);

    assign chan_one_tolerance_sel_out = tol_q[IMLB_TOL1_LO+1:IMLB_TOL1_LO];
    assign chan_two_tolerance_sel_out = tol_q[IMLB_TOL2_LO+1:IMLB_TOL2_LO];
    assign bias_source_sel_out = bias_q[IMLB_BIAS_LO+2:IMLB_BIAS_LO];
    assign bias_pin_is_input_out = bias_source_sel_out == IMLB_BIAS_GPI;
    assign full_scale_sel_out = bias_q[IMLB_FS_LO+1:IMLB_FS_LO];

    property p_mask_reset;
        @(posedge clk_in) $fell(reset_in) |-> event_mask_bits_q == IMLB_MASK_RST;
    endproperty
    a_mask_reset: assert property (p_mask_reset)
        else $error("mask not all ones after reset");

    property p_latch_reset;
        @(posedge clk_in) reset_in |=> event_latch_bits_q == IMLB_LATCH_RST;
    endproperty
    a_latch_reset: assert property (p_latch_reset)
        else $error("latch not zero after reset");

    property p_latch_rsvd;
        @(posedge clk_in) disable iff (reset_in) event_latch_bits_q[2:0] == 3'h0;
    endproperty
    a_latch_rsvd: assert property (p_latch_rsvd)
        else $error("reserved latch bits set");

    property p_read_clear;
        @(posedge clk_in) disable iff (reset_in)
            rd_go && idx == IMLB_IDX_LATCH && ev_pulse == 5'h0
            |=> event_latch_bits_q == 8'h00;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("latch not cleared by read");

    property p_event_sets;
        @(posedge clk_in) disable iff (reset_in)
            clk_en_in && ev_pulse[4] |=> event_latch_bits_q[7];
    endproperty
    a_event_sets: assert property (p_event_sets)
        else $error("event did not latch");

    property p_masked_level;
        @(posedge clk_in) disable iff (reset_in)
            intcfg_q[6:5] == 2'h0 && (event_latch_bits_q & ~event_mask_bits_q
            & IMLB_EVT_BITS) == 8'h00 |-> !pin_active;
    endproperty
    a_masked_level: assert property (p_masked_level)
        else $error("masked event reached pin");

    property p_polarity;
        @(posedge clk_in) disable iff (reset_in)
            irq_active_low_pin_out == (intcfg_q[7] ~^ pin_active);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("pin polarity wrong");

    property p_bias_gpi;
        @(posedge clk_in) disable iff (reset_in)
            bias_q[6:4] == 3'h7 |-> bias_pin_is_input_out;
    endproperty
    a_bias_gpi: assert property (p_bias_gpi)
        else $error("bias code 7 not input");

    property p_readback_masked;
        @(posedge clk_in) disable iff (reset_in)
            intcfg_q[2] |-> (latch_view & event_mask_bits_q) == 8'h00;
    endproperty
    a_readback_masked: assert property (p_readback_masked)
        else $error("masked event visible in readback");
endmodule
`default_nettype wire

//--- logic/imlb_pkg.sv
// constants shared by the interrupt mask/latch and bias config block
package imlb_pkg;
    localparam int IMLB_CLK_HZ = 20000000;
    localparam int IMLB_PULSE_MS = 2;
    localparam int IMLB_PERIOD_MS = 4;
    localparam int IMLB_PULSE_CYC = IMLB_CLK_HZ / 1000 * IMLB_PULSE_MS;
    localparam int IMLB_PERIOD_CYC = IMLB_CLK_HZ / 1000 * IMLB_PERIOD_MS;
    localparam int IMLB_CNT_W = 17;
    // register indices; byte address is four times the index
    localparam logic [7:0] IMLB_IDX_MASK = 8'h33;
    localparam logic [7:0] IMLB_IDX_LATCH = 8'h36;
    localparam logic [7:0] IMLB_IDX_TOL = 8'h3A;
    localparam logic [7:0] IMLB_IDX_BIAS = 8'h3B;
    localparam logic [7:0] IMLB_IDX_INTCFG = 8'h32;
    localparam logic [7:0] IMLB_IDX_STAT = 8'h40;
    localparam logic [7:0] IMLB_IDX_SMASK = 8'h41;
    localparam logic [7:0] IMLB_MASK_RST = 8'hFF;
    localparam logic [7:0] IMLB_LATCH_RST = 8'h00;
    localparam logic [7:0] IMLB_CFG_RST = 8'h00;
    localparam logic [7:0] IMLB_EVT_BITS = 8'hF8;
    localparam logic [7:0] IMLB_TOL_BITS = 8'hF0;
    localparam logic [7:0] IMLB_BIAS_BITS = 8'h73;
    localparam logic [7:0] IMLB_INTCFG_BITS = 8'hE4;
    localparam logic [4:0] IMLB_SMASK_RST = 5'h1F;
    localparam int IMLB_EVT_LO = 3;
    localparam int IMLB_NEVT = 5;
    localparam int IMLB_POL_BIT = 7;
    localparam int IMLB_MODE_LO = 5;
    localparam int IMLB_RDSEL_BIT = 2;
    localparam int IMLB_TOL1_LO = 6;
    localparam int IMLB_TOL2_LO = 4;
    localparam int IMLB_BIAS_LO = 4;
    localparam int IMLB_FS_LO = 0;
    localparam logic [2:0] IMLB_BIAS_GPI = 3'h7;
    typedef enum logic [1:0] {
        IMLB_MODE_LEVEL = 2'h0,
        IMLB_MODE_RSVD = 2'h1,
        IMLB_MODE_REPEAT = 2'h2,
        IMLB_MODE_ONCE = 2'h3
    } imlb_mode_t;
endpackage

//--- logic/imlb_pulse_gen.sv
// pulse shaper for the interrupt pin in timed modes
`timescale 1ns/1ps
`default_nettype none
module imlb_pulse_gen
    import imlb_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire logic [1:0] mode_in,
    input wire logic pending_in,
    input wire logic new_event_in,
    output logic active_out
);
    logic [IMLB_CNT_W-1:0] cnt_q;
    logic running_q;
    imlb_mode_t mode;
    assign mode = imlb_mode_t'(mode_in);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cnt_q <= '0;
            running_q <= 1'b0;
        end else if (enable_in) begin
            if (mode == IMLB_MODE_ONCE) begin
                if (new_event_in) begin
                    running_q <= 1'b1;
                    cnt_q <= '0;
                end else if (running_q) begin
                    if (cnt_q == IMLB_CNT_W'(IMLB_PULSE_CYC - 1)) begin
                        running_q <= 1'b0;
                    end
                    cnt_q <= cnt_q + 1'b1;
                end
            end else if (mode == IMLB_MODE_REPEAT && pending_in) begin
                running_q <= 1'b1;
                if (cnt_q == IMLB_CNT_W'(IMLB_PERIOD_CYC - 1)) begin
                    cnt_q <= '0;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end else begin
                running_q <= 1'b0;
                cnt_q <= '0;
            end
        end
    end

    always_comb begin
        unique case (mode)
            IMLB_MODE_LEVEL: active_out = pending_in;
            IMLB_MODE_RSVD: active_out = 1'b0;
            IMLB_MODE_REPEAT: active_out = pending_in && running_q
                && cnt_q < IMLB_CNT_W'(IMLB_PULSE_CYC);
            IMLB_MODE_ONCE: active_out = running_q;
        endcase
    end
endmodule
`default_nettype wire

//--- bench/imlb_host_model.sv
// host side model: decodes the interrupt pin into an active flag
`timescale 1ns/1ps
`default_nettype none
module imlb_host_model (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic pin_in,
    input wire logic pol_in,
    output logic active_out,
    output logic [15:0] seen_out
);
    assign active_out = pol_in ? pin_in : !pin_in;
    // cycles the interrupt has been seen active
    always_ff @(posedge clk_in) begin
        if (reset_in || !active_out) begin
            seen_out <= 16'h0000;
        end else begin
            seen_out <= seen_out + 16'h0001;
        end
    end
endmodule
`default_nettype wire

//--- bench/imlb_top_bench.sv
// self-checking bench for the interrupt mask/latch and config block
`timescale 1ns/1ps
`default_nettype none
module imlb_top_bench
    import imlb_pkg::*;
;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [9:0] adr = 10'h000;
    logic rd_s = 1'b0;
    logic wr_s = 1'b0;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic wreq;
    logic [4:0] ev = 5'h00;
    logic pin, irq, host_act, bgpi;
    logic pol = 1'b0;
    logic [1:0] tol1, tol2, fs, t1, t2, f;
    logic [2:0] bsel, b;
    logic [15:0] seen;
    logic [31:0] rs = 32'h0000238B;
    logic [31:0] r;
    logic [7:0] mask, v;
    logic [4:0] e;
    int mismatches = 0;
    int n_compared = 0;

    always #25 clk_in = !clk_in;

    imlb_top i_dut (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(1'b1),
        .avs_address_in(adr), .avs_read_in(rd_s), .avs_write_in(wr_s),
        .avs_writedata_in(wdat), .avs_byteenable_in(4'h1),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
        .clk_err_in(ev[4]), .pll_lock_in(ev[3]), .mix_sat_in(ev[2]),
        .vad_up_in(ev[1]), .vad_down_in(ev[0]),
        .irq_active_low_pin_out(pin), .irq_out(irq),
        .chan_one_tolerance_sel_out(tol1), .chan_two_tolerance_sel_out(tol2),
        .bias_source_sel_out(bsel), .bias_pin_is_input_out(bgpi),
        .full_scale_sel_out(fs));

    imlb_host_model i_host (.clk_in(clk_in), .reset_in(reset_in),
        .pin_in(pin), .pol_in(pol), .active_out(host_act), .seen_out(seen));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic [31:0] exp_latch(input logic [4:0] ee,
        input logic [7:0] m, input logic sel);
        return {24'h000000, {ee, 3'h0} & (sel ? ~m : 8'hFF) & 8'hF8};
    endfunction

    task automatic complete_run();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] sv, input logic [31:0] ex);
        n_compared++;
        if (sv !== ex) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, sv, ex);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] idx,
        input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        adr <= {idx, 2'b00};
        wr_s <= w;
        rd_s <= !w;
        wdat <= {24'h000000, d};
        @(posedge clk_in);
        while (wreq !== 1'b0 && n < 50) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 50) check(32'h00000000, 32'h00000001);
        r = rdat;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
    endtask

    task automatic fire(input logic [4:0] x);
        @(posedge clk_in);
        ev <= x;
        repeat (3) @(posedge clk_in);
        ev <= 5'h00;
        repeat (4) @(posedge clk_in);
    endtask

    task automatic chk_irq(input logic x);
        @(posedge clk_in);
        check({31'h0, irq}, {31'h0, x});
    endtask

    initial begin
        #4000000;
        mismatches++;
        complete_run();
    end

    initial begin
        repeat (16) @(posedge clk_in);
        reset_in <= 1'b0;
        bus(0, IMLB_IDX_MASK, 8'h00);
        check(r, 32'h000000FF);
        bus(0, IMLB_IDX_LATCH, 8'h00);
        check(r, 32'h00000000);
        bus(0, IMLB_IDX_TOL, 8'h00);
        check(r, 32'h00000000);
        bus(0, IMLB_IDX_BIAS, 8'h00);
        check(r, 32'h00000000);
        bus(0, 8'h10, 8'h00);
        check(r, 32'h00000000);
        for (int k = 0; k < 24; k++) begin
            rs = xs(rs);
            mask = {rs[7:3], 3'h7};
            v = {rs[8], 4'h0, rs[9], 2'h0};
            e = (k == 0) ? 5'h1F : rs[14:10];
            pol <= rs[8];
            bus(1, IMLB_IDX_INTCFG, v);
            bus(1, IMLB_IDX_MASK, mask);
            bus(0, IMLB_IDX_MASK, 8'h00);
            check(r, {24'h000000, mask});
            fire(e);
            check({31'h0, host_act}, {31'h0, |(e & ~mask[7:3])});
            bus(0, IMLB_IDX_LATCH, 8'h00);
            check(r, exp_latch(e, mask, v[2]));
            bus(0, IMLB_IDX_LATCH, 8'h00);
            check(r, 32'h00000000);
            @(posedge clk_in);
            check({31'h0, host_act}, 32'h00000000);
        end
        // single timed pulse mode, active high pin
        bus(1, IMLB_IDX_MASK, 8'h07);
        pol <= 1'b1;
        bus(1, IMLB_IDX_INTCFG, 8'hE0);
        fire(5'h10);
        check({31'h0, host_act}, 32'h00000001);
        repeat (IMLB_PULSE_CYC - 40) @(posedge clk_in);
        check({31'h0, host_act}, 32'h00000001);
        repeat (40) @(posedge clk_in);
        check({31'h0, host_act}, 32'h00000000);
        bus(0, IMLB_IDX_LATCH, 8'h00);
        check(r, 32'h00000080);
        bus(1, IMLB_IDX_INTCFG, 8'h00);
        pol <= 1'b0;
        bus(1, IMLB_IDX_STAT, 8'h1F);
        bus(1, IMLB_IDX_SMASK, 8'h00);
        chk_irq(1'b0);
        fire(5'h10);
        chk_irq(1'b1);
        bus(0, IMLB_IDX_STAT, 8'h00);
        check(r, 32'h00000010);
        bus(1, IMLB_IDX_SMASK, 8'h10);
        chk_irq(1'b0);
        bus(1, IMLB_IDX_SMASK, 8'h00);
        chk_irq(1'b1);
        bus(1, IMLB_IDX_STAT, 8'h10);
        chk_irq(1'b0);
        for (int k = 0; k < 16; k++) begin
            rs = xs(rs);
            // reserved code 3 never written
            t1 = 2'(rs[3:0] % 3);
            t2 = 2'(rs[7:4] % 3);
            f = 2'(rs[11:8] % 3);
            b = (k == 0) ? 3'h7 : rs[14:12];
            bus(1, IMLB_IDX_TOL, {t1, t2, 4'h0});
            bus(0, IMLB_IDX_TOL, 8'h00);
            check(r, {24'h000000, t1, t2, 4'h0});
            check({30'h0, tol1}, {30'h0, t1});
            check({30'h0, tol2}, {30'h0, t2});
            bus(1, IMLB_IDX_BIAS, {1'b0, b, 2'h0, f});
            bus(0, IMLB_IDX_BIAS, 8'h00);
            check(r, {24'h000000, 1'b0, b, 2'h0, f});
            check({29'h0, bsel}, {29'h0, b});
            check({31'h0, bgpi}, {31'h0, b == 3'h7});
            check({30'h0, fs}, {30'h0, f});
        end
        complete_run();
    end
endmodule
`default_nettype wire
